// [hw/pixel_mixer_consts.svh]
// Purpose: named constants of the cursor and colour-key pixel mixer
// Assumes: included by bare name, definitions only
// Notes:   indexes are those of the indexed register port
`ifndef PIXEL_MIXER_CONSTS_SVH
`define PIXEL_MIXER_CONSTS_SVH

`define IDX_CURSOR_CTL        8'h06
`define IDX_KEY_OVERLAY_LOW   8'h30
`define IDX_KEY_BLUE_HIGH     8'h37
`define IDX_COLOR_KEY_CTL     8'h38

`define CURSOR_CTL_RESET      8'h00
`define COLOR_KEY_CTL_RESET   8'h00
`define KEY_BOUND_RESET       8'h00

`define CCTL_MODE_LSB         0
`define CCTL_MODE_MSB         1
`define CCTL_INTERLACE_BIT    5
`define CCTL_FIELD_INV_BIT    6

`define CKC_POLARITY_BIT      4
`define CKC_ENABLE_MSB        3

`define CURSOR_SIZE           13'h0040
`define CURSOR_Y_MAX          12'hfff
`define CURSOR_Y_INTERLACE    12'h040

`endif

// [hw/pixel_mixer_pkg.sv]
// Purpose: types of the cursor and colour-key pixel mixer
// Assumes: nothing
// Notes:   state widths fixed at 8-bit colour and 12-bit screen counters
package pixel_mixer_pkg;

   typedef enum logic [1:0] {
      CURSOR_OFF         = 2'h0,
      CURSOR_THREE_COLOR = 2'h1,
      CURSOR_COMPLEMENT  = 2'h2,
      CURSOR_TRANSPARENT = 2'h3
   } cursor_mode_type;

   typedef struct packed {
      logic [7:0]       key_ctl;
      logic [7:0][7:0]  bounds;
      logic [7:0]       cursor_ctl;
      logic [7:0]       rdata;
      logic [11:0]      xpos;
      logic [11:0]      line;
      logic             active_d;
      logic             fetch;
      logic [5:0]       row;
      logic [5:0]       col;
      logic             s1_valid;
      logic             s1_palette;
      logic [23:0]      s1_under;
      logic             out_valid;
      logic             out_palette;
      logic [23:0]      out_rgb;
   } mixer_state_type;

endpackage : pixel_mixer_pkg

// [hw/cursor_colorkey_pixel_mixer.sv]
// Purpose: cursor placement and colour-key switching on the pixel stream,
//          between the frame-buffer pixel port and the tables
// Assumes: cursor plane bits arrive in the same clock as the fetch address;
//          position, colours, bypass, mask and page are held elsewhere
// Notes:   two-stage pipeline, output follows input pixel by two clocks;
//          cursor ram loading lives outside this block
//
// Notes on behaviour
// RQ1: position marks cursor bottom-right after blanking end
// RQ2: zero x or y hides cursor
// RQ3: position one,one shows only last pixel top-left
// RQ4: two plane bits fetched per dot in window
// RQ5: mode field selects off, three-color, complement, transparent-first
// RQ6: three-color mode plane bit color mapping
// RQ7: complement mode mapping, eleven inverts pixel
// RQ8: transparent-first mode mapping
// RQ9: indexed or direct control sets enable and mode
// RQ10: interlace bit; field rows when y above 64
// RQ11: even y: even field even rows
// RQ12: odd y: odd field even rows
// RQ13: y below 64: row N on line 0
// RQ14: polarity bit inverts received field input
// RQ15: key is AND of enabled ranges, polarity XOR
// RQ16: inclusive bounds, eight bound registers at 0x30-0x37
// RQ17: compare before gamma, decide every pixel
// RQ18: reset clears enables and polarity, direct default
// RQ19: overlay masked, page fills upper bits
// RQ20: narrow colour fields left-aligned, zero-filled
// RQ21: bypass OR key selects palette graphics
// RQ22: software picks format and sets bypass
// RQ23: suppress cursor outside active area
`include "pixel_mixer_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module cursor_colorkey_pixel_mixer
   import pixel_mixer_pkg::*;
#(
   parameter int RED_BITS     = 8,
   parameter int GREEN_BITS   = 8,
   parameter int BLUE_BITS    = 8,
   parameter int OVERLAY_BITS = 8
) (
   // clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    reset_n,

   // register port
   input  wire logic [7:0]              reg_index,
   input  wire logic [7:0]              reg_wdata,
   input  wire logic                    reg_write,
   input  wire logic                    direct_ctl_write,
   output var  logic [7:0]              reg_rdata_r,

   // cursor setup, owned by other registers
   input  wire logic [11:0]             cursor_x_position,
   input  wire logic [11:0]             cursor_y_position,
   input  wire logic [23:0]             cursor_color0,
   input  wire logic [23:0]             cursor_color1,
   input  wire logic [23:0]             cursor_color2,

   // colour-key side inputs
   input  wire logic                    palette_bypass_select,
   input  wire logic [7:0]              read_mask,
   input  wire logic [7:0]              palette_page,

   // raster timing and pixel stream
   input  wire logic                    display_active,
   input  wire logic                    frame_start,
   input  wire logic                    odd_even_field,
   input  wire logic                    pix_valid,
   input  wire logic [RED_BITS-1:0]     pix_red,
   input  wire logic [GREEN_BITS-1:0]   pix_green,
   input  wire logic [BLUE_BITS-1:0]    pix_blue,
   input  wire logic [OVERLAY_BITS-1:0] pix_overlay,
   input  wire logic [23:0]             pal_rgb,

   // cursor store handshake
   output var  logic                    cursor_fetch_r,
   output var  logic [5:0]              cursor_row_r,
   output var  logic [5:0]              cursor_col_r,
   input  wire logic [1:0]              cursor_plane,

   // mixed pixel towards the tables
   output var  logic                    out_valid_r,
   output var  logic                    out_palette_r,
   output var  logic [23:0]             out_rgb_r
);

   // every field must fit the 8-bit comparators
   if (RED_BITS < 1 || RED_BITS > 8) begin : g_bad_red
      $error("red field width must lie between 1 and 8");
   end

   if (GREEN_BITS < 1 || GREEN_BITS > 8) begin : g_bad_green
      $error("green field width must lie between 1 and 8");
   end

   if (BLUE_BITS < 1 || BLUE_BITS > 8) begin : g_bad_blue
      $error("blue field width must lie between 1 and 8");
   end

   if (OVERLAY_BITS < 1 || OVERLAY_BITS > 8) begin : g_bad_overlay
      $error("overlay field width must lie between 1 and 8");
   end

   localparam logic [7:0] OVL_LOW_MASK = 8'(8'hff >> (8 - OVERLAY_BITS));

   mixer_state_type  state_r;
   mixer_state_type  state_nxt;

   // normalised 8-bit comparator inputs
   logic [7:0]       red8;
   logic [7:0]       green8;
   logic [7:0]       blue8;
   logic [7:0]       ovl8;
   logic [3:0][7:0]  comp;

   // colour-key decision
   logic [3:0]       in_range;
   logic [3:0]       key_hits;
   logic             key_all;
   logic             overlay_in_range;
   logic             key;
   logic             use_palette;

   // cursor control decode
   logic             field_eff;
   logic             interlace_cursor_enable;
   logic             field_polarity_invert;
   cursor_mode_type  mode;

   // cursor window arithmetic, one guard bit for negatives
   logic             row_sel;
   logic [12:0]      cpy13;
   logic [12:0]      cpx13;
   logic [12:0]      row_diff;
   logic [12:0]      col_diff;
   logic             in_window;

   // register decode
   logic             bound_hit;
   logic [2:0]       bound_sel;

   always_comb begin
      state_nxt = state_r;
      red8      = 8'h00;
      green8    = 8'h00;
      blue8     = 8'h00;
      ovl8      = 8'h00;
      comp      = '0;
      in_range  = '0;
      key_hits  = '0;
      key_all   = 1'b0;
      key       = 1'b0;
      row_sel   = 1'b0;
      row_diff  = '0;
      col_diff  = '0;
      in_window = 1'b0;
      bound_hit = 1'b0;
      bound_sel = 3'h0;

      mode = cursor_mode_type'(state_r.cursor_ctl[`CCTL_MODE_MSB:`CCTL_MODE_LSB]);
      interlace_cursor_enable = state_r.cursor_ctl[`CCTL_INTERLACE_BIT];
      field_polarity_invert   = state_r.cursor_ctl[`CCTL_FIELD_INV_BIT];

      // register writes
      bound_hit = (reg_index >= `IDX_KEY_OVERLAY_LOW) && (reg_index <= `IDX_KEY_BLUE_HIGH);
      bound_sel = 3'(reg_index - `IDX_KEY_OVERLAY_LOW);
      if (reg_write) begin
         case (reg_index)
            `IDX_CURSOR_CTL: begin
               state_nxt.cursor_ctl = reg_wdata; // RQ9
            end
            `IDX_COLOR_KEY_CTL: begin
               state_nxt.key_ctl = reg_wdata;
            end
            default: begin
               if (bound_hit) begin
                  state_nxt.bounds[bound_sel] = reg_wdata; // RQ16
               end
            end
         endcase
      end

      // direct control only carries enable and mode
      // it comes later, so it wins on the mode bits if both strobes meet
      if (direct_ctl_write) begin
         state_nxt.cursor_ctl[`CCTL_MODE_MSB:`CCTL_MODE_LSB] =
            reg_wdata[`CCTL_MODE_MSB:`CCTL_MODE_LSB]; // RQ9
      end

      // unmapped indexes read as zero
      case (reg_index)
         `IDX_CURSOR_CTL: begin
            state_nxt.rdata = state_r.cursor_ctl;
         end
         `IDX_COLOR_KEY_CTL: begin
            state_nxt.rdata = state_r.key_ctl;
         end
         default: begin
            state_nxt.rdata = bound_hit ? state_r.bounds[bound_sel] : 8'h00;
         end
      endcase

      // pixel counter restarts at the end of blanking, line counter on frame_start
      state_nxt.active_d = display_active;
      if (!display_active) begin
         state_nxt.xpos = '0; // RQ1
      end else if (pix_valid) begin
         state_nxt.xpos = state_r.xpos + 12'h001;
      end

      // line advances on each fall of active display
      if (frame_start) begin
         state_nxt.line = '0;
      end else if (state_r.active_d && !display_active) begin
         state_nxt.line = state_r.line + 12'h001;
      end

      // colour fields to 8 bits, raw values so before gamma
      red8   = 8'(8'(pix_red) << (8 - RED_BITS)); // RQ20
      green8 = 8'(8'(pix_green) << (8 - GREEN_BITS)); // RQ20
      blue8  = 8'(8'(pix_blue) << (8 - BLUE_BITS)); // RQ20
      ovl8   = ((8'(pix_overlay) & read_mask) & OVL_LOW_MASK) |
               (palette_page & ~OVL_LOW_MASK); // RQ19
      // slot order matches the bound pairs: overlay, red, green, blue
      comp = {blue8, green8, red8, ovl8};
      for (int i = 0; i < 4; i++) begin
         in_range[i] = (state_r.bounds[2*i] <= comp[i]) &&
                       (comp[i] <= state_r.bounds[2*i+1]); // RQ16
      end

      overlay_in_range = in_range[0];
      // a disabled comparator counts as a hit
      key_hits = in_range | ~state_r.key_ctl[`CKC_ENABLE_MSB:0]; // RQ15
      key_all  = &key_hits;
      // polarity 0 inverts, so the reset state keeps direct colour
      key      = key_all ^ ~state_r.key_ctl[`CKC_POLARITY_BIT]; // RQ15 RQ17
      use_palette = palette_bypass_select | key; // RQ21

      // cursor window, offsets so position is the bottom-right corner
      field_eff = odd_even_field ^ field_polarity_invert; // RQ14
      cpy13 = {1'b0, cursor_y_position};
      cpx13 = {1'b0, cursor_x_position};
      col_diff = {1'b0, state_r.xpos} + `CURSOR_SIZE - cpx13; // RQ1 RQ3
      if (interlace_cursor_enable && cursor_y_position > `CURSOR_Y_INTERLACE &&
          cursor_y_position <= `CURSOR_Y_MAX) begin
         // field lines: row parity follows field and position parity
         row_sel  = field_eff ^ cursor_y_position[0]; // RQ10 RQ11 RQ12
         row_diff = {state_r.line, row_sel} -
                    ((cpy13 - `CURSOR_SIZE) & ~13'h0001); // RQ11 RQ12
      end else if (interlace_cursor_enable) begin
         // cursor partly above the top: first shown row on scan line 0
         row_diff = {state_r.line, field_eff} + `CURSOR_SIZE - cpy13; // RQ13
      end else begin
         // progressive scan, one line per row
         row_diff = {1'b0, state_r.line} + `CURSOR_SIZE - cpy13; // RQ1
      end
      // negative differences fail the range test, clipping above and left
      in_window = display_active && pix_valid && (mode != CURSOR_OFF) &&
                  (cursor_x_position != '0) && (cursor_y_position != '0) &&
                  (row_diff[12:6] == '0) && (col_diff[12:6] == '0); // RQ2 RQ5 RQ23

      // stage 1: fetch address, underlying colour
      // address leaves registered, and the plane bits it asks for come back in that same clock
      state_nxt.fetch      = in_window; // RQ4
      state_nxt.row        = row_diff[5:0];
      state_nxt.col        = col_diff[5:0];
      state_nxt.s1_valid   = pix_valid && display_active;
      state_nxt.s1_palette = use_palette;
      state_nxt.s1_under   = use_palette ? pal_rgb : {red8, green8, blue8}; // RQ21

      // stage 2: cursor overlay on the fetched plane bits
      state_nxt.out_valid   = state_r.s1_valid;
      state_nxt.out_palette = state_r.s1_palette;
      state_nxt.out_rgb     = state_r.s1_under;

      if (state_r.fetch) begin
         case (mode)
            // zero shows through, the rest pick a colour
            CURSOR_THREE_COLOR: begin
               case (cursor_plane)
                  2'h1: begin
                     state_nxt.out_rgb = cursor_color0; // RQ6
                  end
                  2'h2: begin
                     state_nxt.out_rgb = cursor_color1; // RQ6
                  end
                  2'h3: begin
                     state_nxt.out_rgb = cursor_color2; // RQ6
                  end
                  default: begin
                     state_nxt.out_rgb = state_r.s1_under; // RQ6
                  end
               endcase
            end

            // eleven flips every bit of the chosen underlying colour
            CURSOR_COMPLEMENT: begin
               case (cursor_plane)
                  2'h0: begin
                     state_nxt.out_rgb = cursor_color0; // RQ7
                  end
                  2'h1: begin
                     state_nxt.out_rgb = cursor_color1; // RQ7
                  end
                  2'h3: begin
                     state_nxt.out_rgb = ~state_r.s1_under; // RQ7
                  end
                  default: begin
                     state_nxt.out_rgb = state_r.s1_under; // RQ7
                  end
               endcase
            end

            // the low half of the codes is see-through
            CURSOR_TRANSPARENT: begin
               case (cursor_plane)
                  2'h2: begin
                     state_nxt.out_rgb = cursor_color0; // RQ8
                  end
                  2'h3: begin
                     state_nxt.out_rgb = cursor_color1; // RQ8
                  end
                  default: begin
                     state_nxt.out_rgb = state_r.s1_under; // RQ8
                  end
               endcase
            end

            default: begin
               state_nxt.out_rgb = state_r.s1_under; // RQ5
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         // named reset values, everything else clears
         state_r            <= '0;
         state_r.key_ctl    <= `COLOR_KEY_CTL_RESET; // RQ18
         state_r.cursor_ctl <= `CURSOR_CTL_RESET;
         state_r.bounds     <= {8{`KEY_BOUND_RESET}};
      end else begin
         state_r <= state_nxt;
      end
   end

   // every output straight from its flip-flop
   assign reg_rdata_r    = state_r.rdata;
   assign cursor_fetch_r = state_r.fetch;
   assign cursor_row_r   = state_r.row;
   assign cursor_col_r   = state_r.col;
   assign out_valid_r    = state_r.out_valid;
   assign out_palette_r  = state_r.out_palette;
   assign out_rgb_r      = state_r.out_rgb;

endmodule : cursor_colorkey_pixel_mixer

`default_nettype wire

// [dv/mixer_monitor.sv]
// Purpose: port checks of the pixel mixer
// Assumes: 8-bit colour fields
// Notes:   bound to every mixer instance
`timescale 1ns/1ps
`default_nettype none
module mixer_monitor (
   input wire logic        core_clk,
   input wire logic        reset_n,
   input wire logic [7:0]  reg_index,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_write,
   input wire logic        direct_ctl_write,
   input wire logic [7:0]  reg_rdata_r,
   input wire logic [11:0] cursor_x_position,
   input wire logic [11:0] cursor_y_position,
   input wire logic        palette_bypass_select,
   input wire logic        display_active,
   input wire logic        pix_valid,
   input wire logic [7:0]  pix_red,
   input wire logic        cursor_fetch_r,
   input wire logic [5:0]  cursor_row_r,
   input wire logic [5:0]  cursor_col_r,
   input wire logic        out_valid_r,
   input wire logic        out_palette_r,
   input wire logic [23:0] out_rgb_r
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   wire logic take = pix_valid && display_active;
   property p_lat; take |-> ##2 out_valid_r; endproperty
   a_lat: assert property (p_lat) else $error("pixel out late");
   property p_fetch; cursor_fetch_r |-> $past(take); endproperty
   a_fetch: assert property (p_fetch) else $error("stray fetch");
   property p_byp; out_valid_r && $past(palette_bypass_select, 2) |-> out_palette_r; endproperty
   a_byp: assert property (p_byp) else $error("bypass ignored");
   property p_hide;
      out_valid_r && !out_palette_r && $past(cursor_x_position, 2) == 12'h000
      |-> out_rgb_r[23:16] == $past(pix_red, 2);
   endproperty
   a_hide: assert property (p_hide) else $error("cursor shown at zero");
   property p_last;
      cursor_fetch_r && $past(cursor_x_position) == 12'h001 && $past(cursor_y_position) == 12'h001
      |-> cursor_row_r == 6'h3f && cursor_col_r == 6'h3f;
   endproperty
   a_last: assert property (p_last) else $error("wrong corner pixel");
   property p_unmap; !(reg_index inside {8'h06, [8'h30:8'h38]}) |=> reg_rdata_r == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   property p_back;
      reg_write && reg_index inside {[8'h30:8'h38]} ##1 !reg_write && $stable(reg_index)
      |=> reg_rdata_r == $past(reg_wdata, 2);
   endproperty
   a_back: assert property (p_back) else $error("bound readback");
   property p_dir;
      direct_ctl_write && reg_index == 8'h06 ##1 !reg_write && !direct_ctl_write && $stable(reg_index)
      |=> reg_rdata_r[1:0] == $past(reg_wdata[1:0], 2);
   endproperty
   a_dir: assert property (p_dir) else $error("direct mode write");
endmodule : mixer_monitor
bind cursor_colorkey_pixel_mixer mixer_monitor mon (.*);
`default_nettype wire

// [dv/cursor_ram_model.sv]
// Purpose: cursor plane store answering the mixer
// Assumes: address registered by the mixer
// Notes:   idle lines toggle so a late read shows
`timescale 1ns/1ps
`default_nettype none
module cursor_ram_model (
   input  wire logic       core_clk,
   input  wire logic       cursor_fetch_r,
   input  wire logic [5:0] cursor_row_r,
   input  wire logic [5:0] cursor_col_r,
   output wire logic [1:0] cursor_plane
);
   logic toggle_r = 1'b0;
   always @(posedge core_clk) toggle_r <= ~toggle_r;
   // row parity mixed in so rows 62 and 63 differ
   assign cursor_plane = cursor_fetch_r ? cursor_col_r[1:0] ^ {1'b0, cursor_row_r[0]}
                                        : {toggle_r, ~toggle_r};
endmodule : cursor_ram_model
`default_nettype wire

// [dv/cursor_colorkey_pixel_mixer_bench.sv]
// Purpose: self-checking bench of the pixel mixer
// Assumes: 8-bit colour fields
// Notes:   outputs queued as they leave, judged per line
`timescale 1ns/1ps
`default_nettype none
module cursor_colorkey_pixel_mixer_bench;
   localparam logic [23:0] col0 = 24'h111111, col1 = 24'h222222;
   localparam logic [23:0] col2 = 24'h333333, pal = 24'h5a5a5a;
   localparam int sel[16] = '{0, 0, 0, 0, 0, 1, 2, 3, 1, 2, 0, 4, 0, 0, 1, 2};
   logic        core_clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, dir_wr = 1'b0;
   logic [7:0]  reg_index = 8'h00, reg_wdata = 8'h00, reg_rdata_r, px_r[4];
   logic        bypass = 1'b0, active = 1'b0, frame_start = 1'b0, pix_valid = 1'b0;
   logic [11:0] cp_x = 12'h000, cp_y = 12'h000;
   logic        field = 1'b0;
   logic [7:0]  red = 8'h00, green = 8'h00, blue = 8'h00;
   logic        fetch_r, out_valid_r, out_palette_r;
   logic [5:0]  row_r, col_r;
   logic [1:0]  plane;
   logic [23:0] out_rgb_r;
   logic [24:0] got[$], exp_v[4];
   int          fail_count = 0, compares = 0, cycles = 0;
   always #2 core_clk = ~core_clk;
   cursor_colorkey_pixel_mixer DUT (.core_clk(core_clk), .reset_n(reset_n),
      .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .direct_ctl_write(dir_wr), .reg_rdata_r(reg_rdata_r), .cursor_x_position(cp_x),
      .cursor_y_position(cp_y), .cursor_color0(col0), .cursor_color1(col1),
      .cursor_color2(col2), .palette_bypass_select(bypass), .read_mask(8'hff),
      .palette_page(8'h00), .display_active(active), .frame_start(frame_start),
      .odd_even_field(field), .pix_valid(pix_valid), .pix_red(red), .pix_green(green),
      .pix_blue(blue), .pix_overlay(8'h00), .pal_rgb(pal), .cursor_fetch_r(fetch_r),
      .cursor_row_r(row_r), .cursor_col_r(col_r), .cursor_plane(plane),
      .out_valid_r(out_valid_r), .out_palette_r(out_palette_r), .out_rgb_r(out_rgb_r));
   cursor_ram_model ram (.core_clk(core_clk), .cursor_fetch_r(fetch_r),
      .cursor_row_r(row_r), .cursor_col_r(col_r), .cursor_plane(plane));
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (out_valid_r === 1'b1)
         got.push_back({out_palette_r, out_rgb_r});
      if (cycles == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   task tally_and_finish();
      if (fail_count == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   task chk(input logic [24:0] seen, input logic [24:0] want);
      compares++;
      if (seen !== want) begin
         fail_count++;
         $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
   endtask : chk
   task wr(input logic [7:0] idx, input logic [7:0] d, input logic dir);
      @(posedge core_clk);
      reg_index <= idx;
      reg_wdata <= d;
      reg_write <= !dir;
      dir_wr <= dir;
      @(posedge core_clk);
      reg_write <= 1'b0;
      dir_wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] idx, input logic [7:0] want);
      @(posedge core_clk);
      reg_index <= idx;
      repeat (2) @(posedge core_clk);
      #1 chk({17'h0, reg_rdata_r}, {17'h0, want});
   endtask : rd
   function automatic logic [24:0] under(input int i, input logic p);
      return p ? {1'b1, pal} : {1'b0, px_r[i], 8'h40 + 8'(i), 8'h80 + 8'(i)};
   endfunction : under
   function automatic logic [24:0] mix(input int m, input int p, input logic [24:0] u);
      logic [24:0] t[5];
      t = '{u, {1'b0, col0}, {1'b0, col1}, {1'b0, col2}, {u[24], ~u[23:0]}};
      return t[sel[m * 4 + p]];
   endfunction : mix
   // palette flag judged only where the cursor stays off
   task run_line(input logic use_pal);
      got.delete();
      @(posedge core_clk);
      frame_start <= 1'b1;
      @(posedge core_clk);
      frame_start <= 1'b0;
      active <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         pix_valid <= 1'b1;
         red <= px_r[i];
         green <= 8'h40 + 8'(i);
         blue <= 8'h80 + 8'(i);
         @(posedge core_clk);
      end
      pix_valid <= 1'b0;
      active <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk(25'(got.size()), 25'd4);
      for (int i = 0; i < 4; i++)
         chk(got[i] & {use_pal, 24'hffffff}, exp_v[i] & {use_pal, 24'hffffff});
   endtask : run_line
   task t_reset();
      rd(8'h38, 8'h00);
      rd(8'h06, 8'h00);
      px_r = '{8'h01, 8'h02, 8'h03, 8'h04};
      for (int i = 0; i < 4; i++) exp_v[i] = under(i, 1'b0);
      run_line(1'b1);
      bypass <= 1'b1;
      for (int i = 0; i < 4; i++) exp_v[i] = under(i, 1'b1);
      run_line(1'b1);
      bypass <= 1'b0;
   endtask : t_reset
   task t_regs();
      for (int i = 0; i < 9; i++) wr(8'h30 + 8'(i), 8'ha0 + 8'(i), 1'b0);
      wr(8'h07, 8'hff, 1'b0);
      for (int i = 0; i < 9; i++) rd(8'h30 + 8'(i), 8'ha0 + 8'(i));
      rd(8'h07, 8'h00);
      wr(8'h06, 8'h61, 1'b0);
      wr(8'h06, 8'hfe, 1'b1);
      rd(8'h06, 8'h62);
   endtask : t_regs
   task t_key();
      wr(8'h32, 8'h10, 1'b0);
      wr(8'h33, 8'h20, 1'b0);
      wr(8'h38, 8'h12, 1'b0);
      px_r = '{8'h0f, 8'h10, 8'h20, 8'h21};
      for (int i = 0; i < 4; i++) exp_v[i] = under(i, i == 1 || i == 2);
      run_line(1'b1);
      wr(8'h38, 8'h02, 1'b0);
      for (int i = 0; i < 4; i++) exp_v[i] = under(i, i == 0 || i == 3);
      run_line(1'b1);
   endtask : t_key
   task t_cursor();
      wr(8'h38, 8'h00, 1'b0);
      px_r = '{8'h00, 8'h10, 8'h20, 8'h30};
      cp_x <= 12'h040;
      cp_y <= 12'h040;
      for (int m = 0; m < 4; m++) begin
         wr(8'h06, 8'(m), 1'b0);
         for (int i = 0; i < 4; i++) exp_v[i] = mix(m, i, under(i, 1'b0));
         run_line(1'b0);
      end
      wr(8'h06, 8'h01, 1'b0);
      cp_x <= 12'h001;
      cp_y <= 12'h001;
      for (int i = 0; i < 4; i++) exp_v[i] = i == 0 ? {1'b0, col1} : under(i, 1'b0);
      run_line(1'b0);
      cp_x <= 12'h000;
      cp_y <= 12'h040;
      for (int i = 0; i < 4; i++) exp_v[i] = under(i, 1'b0);
      run_line(1'b0);
   endtask : t_cursor
   task t_interlace();
      cp_x <= 12'h040;
      cp_y <= 12'h040;
      field <= 1'b1;
      wr(8'h06, 8'h21, 1'b0);
      for (int i = 0; i < 4; i++) exp_v[i] = mix(1, i ^ 1, under(i, 1'b0));
      run_line(1'b0);
      wr(8'h06, 8'h61, 1'b0);
      for (int i = 0; i < 4; i++) exp_v[i] = mix(1, i, under(i, 1'b0));
      run_line(1'b0);
   endtask : t_interlace
   initial begin
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      t_reset();
      t_regs();
      t_key();
      t_cursor();
      t_interlace();
      tally_and_finish();
   end
endmodule : cursor_colorkey_pixel_mixer_bench
`default_nettype wire
